// ==== hw/fid_pkg.sv ====
// constants and types of the identification / one-time sector controller
// assumes one 50 MHz clock; serial pins arrive unsynchronised
package fid_pkg;

    // ==========================================
    // timing
    localparam int unsigned CLK_HZ     = 50_000_000;
    localparam int unsigned PUW_MIN_MS = 1;
    localparam int unsigned PUW_CYCLES = PUW_MIN_MS * (CLK_HZ / 1000);

    // ==========================================
    // opcodes
    localparam logic [7:0] OP_ID_PAIR    = 8'h90;
    localparam logic [7:0] OP_ID_JEDEC   = 8'h9f;
    localparam logic [7:0] OP_OTP_ENTER  = 8'h3a;
    localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
    localparam logic [7:0] OP_WRITE_EN   = 8'h06;
    localparam logic [7:0] OP_STATUS_RD  = 8'h05;
    localparam logic [7:0] OP_STATUS_WR  = 8'h01;
    localparam logic [7:0] OP_PROG       = 8'h02;
    localparam logic [7:0] OP_SERASE     = 8'h20;
    localparam logic [7:0] OP_BERASE_A   = 8'hd8;
    localparam logic [7:0] OP_BERASE_B   = 8'h52;
    localparam logic [7:0] OP_CERASE_A   = 8'hc7;
    localparam logic [7:0] OP_CERASE_B   = 8'h60;

    // ==========================================
    // identity bytes, values arbitrary
    localparam logic [7:0] MAN_ID   = 8'h5a;
    localparam logic [7:0] DEV_ID   = 8'h10;
    localparam logic [7:0] MEM_TYPE = 8'h31;
    localparam logic [7:0] MEM_CAP  = 8'h11;

    // ==========================================
    // addresses and status layout
    localparam logic [23:0] ID_ADDR_SWAP = 24'h000001;
    localparam logic [23:0] OTP_BASE     = 24'h01f000;
    localparam logic [23:0] OTP_LAST     = 24'h01f0ff;
    localparam int unsigned ST_WIP_BIT   = 0;
    localparam int unsigned ST_WEL_BIT   = 1;
    localparam int unsigned ST_BP_LSB    = 2;
    localparam int unsigned ST_SRP_BIT   = 7;
    localparam logic [7:0]  STATUS_RESET = 8'h00;

    // ==========================================
    // types
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } fid_pins_t;

    localparam fid_pins_t PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};

    typedef enum logic [1:0] {
        KIND_PROG, KIND_SERASE, KIND_BERASE, KIND_CERASE
    } fid_kind_t;

    typedef struct packed {
        logic        start;
        fid_kind_t   kind;
        logic [23:0] addr;
        logic        otp;
    } fid_op_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } fid_byte_t;

    typedef enum {
        ST_CMD, ST_ADDR, ST_DATA, ST_OUT, ST_WAIT_CS, ST_IGNORE
    } fid_state_t;

endpackage

// ==== hw/fid_ctrl.sv ====
// serial instruction front end: identification reads, status access,
// one-time sector mode and program / erase gating
// assumes the array engine runs on ref_clk and reports array_busy
`timescale 1ns/1ps

// Notes on behaviour
// - 90h plus address zero returns maker, part
// - output bits change on falling clock, msb first
// - address 000001h returns part code first
// - 9Fh returns maker, type, capacity bytes
// - identification opcodes ignored while array busy
// - 24 identity bits follow the 9Fh opcode, 16 after the 90h address
// - raising select ends output, driver released
// - select high returns to standby, waits
// - 3Ah enters one-time sector mode
// - one-time sector sits at 01F000h-01F0FFh
// - protect bit reads as lock in mode
// - lock set blocks program and erase in mode
// - status write in mode sets lock permanently
// - sector writable only unlocked with protect 000
// - other sectors writable in mode only unlocked
// - 04h leaves one-time sector mode
// - only 20h erases the one-time sector
// - writes rejected during power-up delay
// - status reads 00h after reset
// - program or erase needs write enable latch
module fid_ctrl #(
    parameter int unsigned PUW_CYCLES_P = fid_pkg::PUW_CYCLES
) (
    input  wire logic              ref_clk,            // 50 MHz clock
    input  wire logic              rst,                // async reset
    input  wire fid_pkg::fid_pins_t spi_pins,          // raw serial pins
    input  wire logic              array_busy,         // array cycle running
    output logic                   miso_data,          // serial out level
    output logic                   miso_oe,            // serial out drive
    output fid_pkg::fid_op_t       array_op,           // granted operation
    output fid_pkg::fid_byte_t     prog_byte,          // program data byte
    output logic                   otp_mode,           // sector mode active
    output logic                   otp_lock,           // lock bit
    output logic                   write_enable_latch, // latch state
    output logic                   powerup_done        // writes accepted
);
    import fid_pkg::*;

    // ==========================================
    // pin synchroniser
    fid_pins_t pin_s1_r, pin_s2_r, pin_s3_r;
    fid_pins_t pin_f_r, pin_f_nxt;
    fid_pins_t pin_p_r;
    logic      sclk_rise, sclk_fall, cs_rise;

    // a change counts once stages two and three agree
    always_comb begin
        pin_f_nxt = fid_pins_t'((~(pin_s2_r ^ pin_s3_r) & pin_s3_r)
                              | ((pin_s2_r ^ pin_s3_r) & pin_f_r));
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
            pin_s3_r <= PIN_IDLE;
            pin_f_r  <= PIN_IDLE;
            pin_p_r  <= PIN_IDLE;
        end else begin
            pin_s1_r <= spi_pins;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r  <= pin_f_nxt;
            pin_p_r  <= pin_f_r;
        end
    end

    assign sclk_rise = pin_f_r.sclk & ~pin_p_r.sclk;
    assign sclk_fall = ~pin_f_r.sclk & pin_p_r.sclk;
    assign cs_rise   = pin_f_r.cs_n & ~pin_p_r.cs_n;

    // ==========================================
    // power-up write delay
    logic [31:0] pup_cnt_r, pup_cnt_nxt;
    logic        pup_done_r, pup_done_nxt;

    always_comb begin
        pup_cnt_nxt  = pup_cnt_r;
        pup_done_nxt = pup_done_r;
        if (!pup_done_r) begin
            if (pup_cnt_r == PUW_CYCLES_P - 32'd1) begin
                pup_done_nxt = 1'b1;
            end else begin
                pup_cnt_nxt = pup_cnt_r + 32'd1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pup_cnt_r  <= 32'h0;
            pup_done_r <= 1'b0;
        end else begin
            pup_cnt_r  <= pup_cnt_nxt;
            pup_done_r <= pup_done_nxt;
        end
    end

    // ==========================================
    // instruction engine
    fid_state_t  state_r, state_nxt;
    logic [4:0]  bit_cnt_r, bit_cnt_nxt;
    logic [23:0] in_sr_r, in_sr_nxt;
    logic [23:0] shifted;
    logic [7:0]  cmd_r, cmd_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [23:0] out_vec_r, out_vec_nxt;
    logic [4:0]  out_idx_r, out_idx_nxt;
    logic [4:0]  out_last_r, out_last_nxt;
    logic [4:0]  out_pos;
    logic        out_bit;
    logic [7:0]  status_live;
    logic [7:0]  st_data_r, st_data_nxt;
    logic        miso_r, miso_nxt;
    logic        oe_r, oe_nxt;
    logic        wel_r, wel_nxt;
    logic        srp_r, srp_nxt;
    logic [2:0]  bp_r, bp_nxt;
    logic        lock_r, lock_nxt;
    logic        otp_r, otp_nxt;
    logic        prog_ok_r, prog_ok_nxt;
    logic        first_r, first_nxt;
    fid_op_t     op_r, op_nxt;
    fid_byte_t   byte_r, byte_nxt;

    assign shifted = {in_sr_r[22:0], pin_f_r.mosi};
    assign out_pos = 5'd23 - out_idx_r;

    // protect position shows lock in mode
    always_comb begin
        status_live             = STATUS_RESET;
        status_live[ST_SRP_BIT] = otp_r ? lock_r : srp_r;
        status_live[ST_BP_LSB +: 3] = bp_r;
        status_live[ST_WEL_BIT] = wel_r;
        status_live[ST_WIP_BIT] = array_busy;
    end

    assign out_bit = (cmd_r == OP_STATUS_RD) ?
                     status_live[~out_idx_r[2:0]] : out_vec_r[out_pos];

    // target inside the one-time sector window
    function automatic logic otp_target(input fid_kind_t k,
                                        input logic [23:0] a);
        return otp_r && (k == KIND_PROG || k == KIND_SERASE)
               && a >= OTP_BASE && a <= OTP_LAST;
    endfunction

    // write permission for program and erase
    function automatic logic op_allowed(input fid_kind_t k,
                                        input logic [23:0] a);
        logic ok;
        ok = wel_r & pup_done_r & ~array_busy;
        if (otp_r) begin
            ok = ok & ~lock_r;
            if (otp_target(k, a)) begin
                ok = ok & (bp_r == 3'h0);
            end
        end
        return ok;
    endfunction

    always_comb begin
        fid_kind_t er_kind;
        logic      er_req;
        logic      ok;
        er_kind      = KIND_SERASE;
        er_req       = 1'b0;
        ok           = 1'b0;
        state_nxt    = state_r;
        bit_cnt_nxt  = bit_cnt_r;
        in_sr_nxt    = in_sr_r;
        cmd_nxt      = cmd_r;
        addr_nxt     = addr_r;
        out_vec_nxt  = out_vec_r;
        out_idx_nxt  = out_idx_r;
        out_last_nxt = out_last_r;
        st_data_nxt  = st_data_r;
        miso_nxt     = miso_r;
        oe_nxt       = oe_r;
        wel_nxt      = wel_r;
        srp_nxt      = srp_r;
        bp_nxt       = bp_r;
        lock_nxt     = lock_r;
        otp_nxt      = otp_r;
        prog_ok_nxt  = prog_ok_r;
        first_nxt    = first_r;
        op_nxt       = op_r;
        op_nxt.start = 1'b0;
        byte_nxt     = byte_r;
        byte_nxt.vld = 1'b0;
        if (pin_f_r.cs_n) begin
            state_nxt   = ST_CMD;
            bit_cnt_nxt = 5'd0;
            oe_nxt      = 1'b0;
            if (cs_rise && state_r == ST_WAIT_CS) begin
                case (cmd_r)
                    OP_WRITE_EN: begin
                        if (pup_done_r && !array_busy) begin
                            wel_nxt = 1'b1;
                        end
                    end
                    OP_WRITE_DIS: begin
                        wel_nxt = 1'b0;
                        otp_nxt = 1'b0;
                    end
                    OP_OTP_ENTER: begin
                        if (!array_busy) begin
                            otp_nxt = 1'b1;
                        end
                    end
                    OP_STATUS_WR: begin
                        if (wel_r && pup_done_r && !array_busy) begin
                            wel_nxt = 1'b0;
                            if (otp_r) begin
                                lock_nxt = 1'b1;
                            end else begin
                                srp_nxt = st_data_r[ST_SRP_BIT];
                                bp_nxt  = st_data_r[ST_BP_LSB +: 3];
                            end
                        end
                    end
                    OP_SERASE: begin
                        er_req  = 1'b1;
                        er_kind = KIND_SERASE;
                    end
                    OP_BERASE_A, OP_BERASE_B: begin
                        er_req  = 1'b1;
                        er_kind = KIND_BERASE;
                    end
                    OP_CERASE_A, OP_CERASE_B: begin
                        er_req  = 1'b1;
                        er_kind = KIND_CERASE;
                    end
                    default: begin
                    end
                endcase
                if (er_req && op_allowed(er_kind, addr_r)) begin
                    // only sector erase reaches the sector
                    op_nxt.start = 1'b1;
                    op_nxt.kind  = er_kind;
                    op_nxt.addr  = addr_r;
                    op_nxt.otp   = otp_target(er_kind, addr_r);
                    wel_nxt      = 1'b0;
                end
            end
        end else if (sclk_rise) begin
            bit_cnt_nxt = bit_cnt_r + 5'd1;
            in_sr_nxt   = shifted;
            case (state_r)
                ST_CMD: begin
                    if (bit_cnt_r == 5'd7) begin
                        bit_cnt_nxt = 5'd0;
                        cmd_nxt     = shifted[7:0];
                        out_idx_nxt = 5'd0;
                        case (shifted[7:0])
                            OP_ID_PAIR: begin
                                state_nxt = array_busy ? ST_IGNORE : ST_ADDR;
                            end
                            OP_ID_JEDEC: begin
                                state_nxt    = array_busy ? ST_IGNORE : ST_OUT;
                                out_vec_nxt  = {MAN_ID, MEM_TYPE, MEM_CAP};
                                out_last_nxt = 5'd23;
                            end
                            OP_STATUS_RD: begin
                                state_nxt    = ST_OUT;
                                out_last_nxt = 5'd7;
                            end
                            OP_WRITE_EN, OP_WRITE_DIS, OP_OTP_ENTER,
                            OP_CERASE_A, OP_CERASE_B: begin
                                state_nxt = ST_WAIT_CS;
                            end
                            OP_STATUS_WR: begin
                                state_nxt = ST_DATA;
                            end
                            OP_PROG, OP_SERASE,
                            OP_BERASE_A, OP_BERASE_B: begin
                                state_nxt = ST_ADDR;
                            end
                            default: begin
                                state_nxt = ST_IGNORE;
                            end
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (bit_cnt_r == 5'd23) begin
                        bit_cnt_nxt = 5'd0;
                        addr_nxt    = shifted;
                        first_nxt   = 1'b1;
                        if (cmd_r == OP_ID_PAIR) begin
                            state_nxt    = ST_OUT;
                            out_last_nxt = 5'd15;
                            if (shifted == ID_ADDR_SWAP) begin
                                out_vec_nxt = {DEV_ID, MAN_ID, 8'h00};
                            end else begin
                                out_vec_nxt = {MAN_ID, DEV_ID, 8'h00};
                            end
                        end else if (cmd_r == OP_PROG) begin
                            state_nxt = ST_DATA;
                        end else begin
                            state_nxt = ST_WAIT_CS;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_cnt_r == 5'd7) begin
                        bit_cnt_nxt = 5'd0;
                        if (cmd_r == OP_STATUS_WR) begin
                            st_data_nxt = shifted[7:0];
                            state_nxt   = ST_WAIT_CS;
                        end else begin
                            // first byte decides the grant
                            ok = first_r ? op_allowed(KIND_PROG, addr_r)
                                         : prog_ok_r;
                            if (first_r) begin
                                op_nxt.start = ok;
                                op_nxt.kind  = KIND_PROG;
                                op_nxt.addr  = addr_r;
                                op_nxt.otp   = otp_target(KIND_PROG, addr_r);
                                if (ok) begin
                                    wel_nxt = 1'b0;
                                end
                            end
                            prog_ok_nxt   = ok;
                            first_nxt     = 1'b0;
                            byte_nxt.vld  = ok;
                            byte_nxt.data = shifted[7:0];
                        end
                    end
                end
                ST_WAIT_CS: begin
                    // surplus bits cancel the instruction
                    state_nxt = ST_IGNORE;
                end
                default: begin
                end
            endcase
        end else if (sclk_fall && state_r == ST_OUT) begin
            miso_nxt    = out_bit;
            oe_nxt      = 1'b1;
            out_idx_nxt = (out_idx_r == out_last_r) ? 5'd0
                                                    : out_idx_r + 5'd1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_CMD;
            bit_cnt_r  <= 5'd0;
            in_sr_r    <= 24'h0;
            cmd_r      <= 8'h00;
            addr_r     <= 24'h0;
            out_vec_r  <= 24'h0;
            out_idx_r  <= 5'd0;
            out_last_r <= 5'd0;
            st_data_r  <= 8'h00;
            miso_r     <= 1'b0;
            oe_r       <= 1'b0;
            wel_r      <= STATUS_RESET[ST_WEL_BIT];
            srp_r      <= STATUS_RESET[ST_SRP_BIT];
            bp_r       <= STATUS_RESET[ST_BP_LSB +: 3];
            lock_r     <= 1'b0;
            otp_r      <= 1'b0;
            prog_ok_r  <= 1'b0;
            first_r    <= 1'b0;
            op_r       <= '0;
            byte_r     <= '0;
        end else begin
            state_r    <= state_nxt;
            bit_cnt_r  <= bit_cnt_nxt;
            in_sr_r    <= in_sr_nxt;
            cmd_r      <= cmd_nxt;
            addr_r     <= addr_nxt;
            out_vec_r  <= out_vec_nxt;
            out_idx_r  <= out_idx_nxt;
            out_last_r <= out_last_nxt;
            st_data_r  <= st_data_nxt;
            miso_r     <= miso_nxt;
            oe_r       <= oe_nxt;
            wel_r      <= wel_nxt;
            srp_r      <= srp_nxt;
            bp_r       <= bp_nxt;
            lock_r     <= lock_nxt;
            otp_r      <= otp_nxt;
            prog_ok_r  <= prog_ok_nxt;
            first_r    <= first_nxt;
            op_r       <= op_nxt;
            byte_r     <= byte_nxt;
        end
    end

    assign miso_data          = miso_r;
    assign miso_oe            = oe_r;
    assign array_op           = op_r;
    assign prog_byte          = byte_r;
    assign otp_mode           = otp_r;
    assign otp_lock           = lock_r;
    assign write_enable_latch = wel_r;
    assign powerup_done       = pup_done_r;

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_OE_OFF_DESELECT: assert property (
        pin_f_r.cs_n |=> !miso_oe)
        else $error("output driven while deselected");

    AST_SHIFT_ON_FALL: assert property (
        ($changed(miso_data) && miso_oe) |-> $past(sclk_fall))
        else $error("output changed without falling clock");

    AST_LOCK_STICKY: assert property (
        otp_lock |=> otp_lock)
        else $error("lock bit cleared");

    AST_LOCKED_NO_OP: assert property (
        array_op.start |-> !(otp_mode && otp_lock))
        else $error("operation granted while locked");

    AST_OTP_BP_CLEAR: assert property (
        (array_op.start && array_op.otp) |-> bp_r == 3'h0)
        else $error("sector write with protect field set");

    AST_OTP_ERASE_SE: assert property (
        (array_op.start && array_op.otp)
        |-> array_op.kind inside {KIND_PROG, KIND_SERASE})
        else $error("sector reached by wrong erase");

    AST_OTP_WINDOW: assert property (
        (array_op.start && array_op.otp)
        |-> array_op.addr[23:8] == OTP_BASE[23:8])
        else $error("sector grant outside window");

    AST_WEL_CONSUMED: assert property (
        array_op.start |-> $past(write_enable_latch)
                           && !write_enable_latch)
        else $error("grant without latch or latch kept");

    AST_PUW_NO_WRITE: assert property (
        !powerup_done |-> !write_enable_latch && !array_op.start)
        else $error("write accepted during hold-off");

    AST_WRITE_DISABLE_CMD_EXIT: assert property (
        (cs_rise && state_r == ST_WAIT_CS && cmd_r == OP_WRITE_DIS)
        |=> !otp_mode ##1 !otp_mode)
        else $error("write disable kept sector mode");

    AST_BUSY_ID_IGNORED: assert property (
        (sclk_rise && !pin_f_r.cs_n && state_r == ST_CMD
         && bit_cnt_r == 5'd7 && array_busy
         && shifted[7:0] == OP_ID_JEDEC) |=> state_r == ST_IGNORE)
        else $error("identification decoded while busy");

endmodule

// ==== dv/fid_host.sv ====
// host serial controller model driving select, clock and data pins
// assumes the device filters its pins on ref_clk; each clock level stands 8 cycles
`timescale 1ns/1ps
module fid_host (
    input  wire logic          ref_clk,   // sampling clock
    output fid_pkg::fid_pins_t pins,      // select, clock, data
    input  wire logic          miso_data, // device data out
    input  wire logic          miso_oe    // device drive enable
);
    import fid_pkg::*;
    logic seen_oe; // device drove output in last frame
    initial pins = PIN_IDLE;
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // ====
    // frame: opcode, address, data out; then clock in reply bits
    // whole frames, select after
    task automatic frame(input logic [39:0] tx, input int ntx,
                         input int nrx, output logic [23:0] rx);
        rx = '0;
        seen_oe = 1'b0;
        pins.cs_n <= 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            if (i < ntx) pins.mosi <= tx[ntx-1-i];
            else pins.mosi <= ~pins.mosi;
            hold(8);
            seen_oe = seen_oe | miso_oe;
            if (i >= ntx) rx = {rx[22:0], miso_data};
            pins.sclk <= 1'b1;
            hold(8);
            pins.sclk <= 1'b0;
        end
        hold(8);
        pins.cs_n <= 1'b1;
        hold(10);
    endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench: identification reads and one-time sector mode
// assumes fid_pkg, fid_ctrl and fid_host are compiled first
`timescale 1ns/1ps
module tb;
    import fid_pkg::*;
    logic        ref_clk, rst, array_busy, miso_data, miso_oe;
    logic        otp_mode, otp_lock, write_enable_latch, powerup_done;
    fid_pins_t   spi_pins;
    fid_op_t     array_op;
    fid_byte_t   prog_byte;
    logic [23:0] rx;
    logic [7:0]  pdat;
    logic [26:0] exp_q[$];
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    fid_ctrl #(.PUW_CYCLES_P(20)) dut (.ref_clk, .rst, .spi_pins,
        .array_busy, .miso_data, .miso_oe, .array_op, .prog_byte,
        .otp_mode, .otp_lock, .write_enable_latch, .powerup_done);
    fid_host host (.ref_clk, .pins(spi_pins), .miso_data, .miso_oe);
    // ====
    // checking
    task automatic check(input logic [26:0] seen, input logic [26:0] want);
        cmp_count++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic take(input logic [26:0] seen);
        logic [26:0] want;
        want = exp_q.size() ? exp_q.pop_front() : 'x;
        check(seen, want);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        // grants and program bytes against the notes
        if (array_op.start) begin
            take({array_op.kind, array_op.addr, array_op.otp});
        end
        if (prog_byte.vld) begin
            take({19'h0, prog_byte.data});
        end
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ====
    // stimulus
    task automatic rd(input logic [39:0] tx, input int ntx, input int nb,
                      input logic [23:0] want);
        for (int k = 0; k < nb; k++) exp_q.push_back(want[8*(nb-1-k)+:8]);
        host.frame(tx, ntx, 8 * nb, rx);
        for (int k = 0; k < nb; k++) take(rx[8*(nb-1-k)+:8]);
        check(miso_oe, 0);
    endtask
    task automatic cmd(input logic [39:0] tx, input int ntx);
        host.frame(tx, ntx, 0, rx);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        rst = 1'b1;
        array_busy = 1'b0;
        void'($urandom(66));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        check(powerup_done, 0);
        repeat (30) @(posedge ref_clk);
        check(powerup_done, 1);
        rd(40'h9f, 8, 3, {MAN_ID, MEM_TYPE, MEM_CAP});
        // cut a read in mid-byte, then a fresh read must decode
        exp_q.push_back(MAN_ID);
        host.frame(40'h9f, 8, 12, rx);
        take(rx[11:4]);
        check(miso_oe, 0);
        rd(40'h90000000, 32, 2, {8'h00, MAN_ID, DEV_ID});
        rd(40'h90000001, 32, 2, {8'h00, DEV_ID, MAN_ID});
        rd(40'h05, 8, 1, {16'h0000, STATUS_RESET});
        array_busy <= 1'b1;
        cmd(40'h9f00, 16);
        check(host.seen_oe, 0);
        array_busy <= 1'b0;
        $display("identification tests done");
        cmd(40'h3a, 8);
        check(otp_mode, 1);
        cmd(40'h06, 8);
        check(write_enable_latch, 1);
        exp_q.push_back({KIND_SERASE, OTP_BASE, 1'b1});
        cmd(40'h2001f000, 32);
        cmd(40'h06, 8);
        pdat = 8'($urandom);
        exp_q.push_back({KIND_PROG, OTP_BASE, 1'b1});
        exp_q.push_back({19'h0, pdat});
        cmd({OP_PROG, OTP_BASE, pdat}, 40);
        cmd(40'h06, 8);
        cmd({24'h0, 8'h01, 8'($urandom)}, 16);
        check(otp_lock, 1);
        rd(40'h05, 8, 1, 24'h000080);
        cmd(40'h06, 8);
        cmd(40'h2001f000, 32);
        cmd(40'h20000000, 32);
        check(exp_q.size(), 0);
        check(write_enable_latch, 1);
        cmd(40'h04, 8);
        check(otp_mode, 0);
        check(write_enable_latch, 0);
        $display("sector mode tests done");
        tally_and_finish();
    end
endmodule
